// ===== hdl/aic_cfg.svh
// Offsets, field positions, reset values and phase lengths of the A/D control block.
`ifndef AIC_CFG_SVH
`define AIC_CFG_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define AIC_OFS_CTRL_A 8'h00
`define AIC_OFS_CTRL_B 8'h04
`define AIC_OFS_CTRL_C 8'h08
`define AIC_OFS_RES_H  8'h0c
`define AIC_OFS_RES_L  8'h10
`define AIC_OFS_INT    8'h14
`define AIC_OFS_PIN    8'h18

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define AIC_A_START 0
`define AIC_A_BUSY  1
`define AIC_A_FMT   2
`define AIC_A_PWR   3
`define AIC_A_CHAN  4
`define AIC_B_DIV   0
`define AIC_B_REF   4
`define AIC_B_INS   8
`define AIC_C_RES   0
`define AIC_C_MODE  1
`define AIC_C_TEMP_SENSOR_ENABLE  3
`define AIC_I_GIE   0
`define AIC_I_AIE   1
`define AIC_I_FLAG  2

// ----------------------------------------------------------------------------
// Reset values and codes
// ----------------------------------------------------------------------------
`define AIC_RST_DIV    3'h0
`define AIC_RST_REF    2'h0
`define AIC_RST_INS    3'h0
`define AIC_RST_CHAN   4'h0
`define AIC_RST_MODE   2'h0
`define AIC_MODE_LOWI  2'h3
`define AIC_INS_BG     3'h1
`define AIC_INS_TSO    3'h2
`define AIC_INS_GND_A  3'h3
`define AIC_INS_GND_B  3'h4
`define AIC_INS_BAD    3'h7
`define AIC_RESP_OKAY  2'h0
`define AIC_RESP_SLV   2'h2

// ----------------------------------------------------------------------------
// Phase lengths in A/D clocks
// ----------------------------------------------------------------------------
`define AIC_SAMP_12    6'd4
`define AIC_SAMP_TSO   6'd46
`define AIC_SAMP_10    6'd3
`define AIC_SAMP_10LI  6'd2
`define AIC_CONV_12    4'd12
`define AIC_CONV_10    4'd10

`endif

// ===== hdl/aic_pkg.sv
// Types and shared decode functions of the A/D control block.
package aic_pkg;
`include "aic_cfg.svh"

  typedef enum logic [2:0]
  {
    AIC_IDLE   = 3'b001,
    AIC_SAMPLE = 3'b010,
    AIC_CONV   = 3'b100
  } aic_state_e;

  typedef struct packed
  {
    logic [7:0] ext_en;
    logic       bandgap_en;
    logic       tso_en;
    logic       gnd_en;
    logic [2:0] ref_en;
  } aic_route_s;

  function automatic logic aic_is_ext(input logic [2:0] ins);
    return (ins == 3'h0) || (ins == 3'h5) || (ins == 3'h6);
  endfunction

  function automatic logic [5:0] aic_samp_len(input logic res10, input logic [1:0] mode,
                                               input logic [2:0] ins);
    if (!res10)
      return (ins == `AIC_INS_TSO) ? `AIC_SAMP_TSO : `AIC_SAMP_12;
    return (mode == `AIC_MODE_LOWI) ? `AIC_SAMP_10LI : `AIC_SAMP_10;
  endfunction
endpackage

// ===== hdl/aic_clk_div.sv
// A/D clock tick generator: one tick every 2**div_sel system clocks.
`timescale 1ns/1ns
module aic_clk_div #(
  parameter int DIV_W = 3
) (
  // Clock and reset
  input  wire logic             aclk,
  input  wire logic             aresetn,
  // Control
  input  wire logic [DIV_W-1:0] div_sel,
  input  wire logic             run,
  // Tick
  output logic                  tick
);
  localparam int CW = (1 << DIV_W) - 1;

  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] mask;

  // The count restarts whenever the converter is idle so a conversion always
  // begins on a fresh A/D clock.
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !run)
      cnt_reg <= '0;
    else
      cnt_reg <= cnt_reg + 1'b1;
  end

  assign mask = CW'((32'd1 << div_sel) - 32'd1);
  // The tick closes each A/D clock period, so a phase of n A/D clocks spans n full periods.
  assign tick = run && ((cnt_reg & mask) == mask);
endmodule

// ===== hdl/aic_input_mux.sv
// Decode of reference and converter input selection into switch enables.
`timescale 1ns/1ns
module aic_input_mux
  import aic_pkg::*;
#(
  parameter int N_CH = 8
) (
  // Selection
  input  wire logic [2:0] ins_sel,
  input  wire logic [3:0] chan_sel,
  input  wire logic [1:0] ref_sel,
  // Switch enables
  output aic_route_s      route
);
  logic ext_mode;

  assign ext_mode = aic_is_ext(ins_sel);

  // A code above the fitted channels closes no switch and the input floats.
  genvar i;
  generate
    for (i = 0; i < 8; i++)
    begin : g_ch
      assign route.ext_en[i] = ext_mode && (i < N_CH) && (chan_sel == 4'(i));
    end
  endgenerate

  assign route.bandgap_en = (ins_sel == `AIC_INS_BG);
  assign route.tso_en     = (ins_sel == `AIC_INS_TSO);
  assign route.gnd_en     = (ins_sel == `AIC_INS_GND_A) || (ins_sel == `AIC_INS_GND_B);

  assign route.ref_en[0] = (ref_sel == 2'h0);
  assign route.ref_en[1] = ref_sel[0];
  assign route.ref_en[2] = (ref_sel == 2'h2);
endmodule

// ===== hdl/aic_ctrl.sv
// A/D converter input, reference and conversion sequencing with AXI4-Lite registers.
// Function
// - Reference field routes pin, supply or sensor.
// - Codes 000/101/110 connect chosen external channel.
// - Channel codes beyond fitted pins float.
// - Internal codes select bandgap, sensor, ground.
// - Analog pin drops digital functions and pull-up.
// - Analog function overrides port direction.
// - 12-bit: 4 sample plus 12 convert.
// - 12-bit sensor: 46 sample plus 12.
// - 10-bit low current: 2 plus 10.
// - 10-bit other modes: 3 plus 10.
// - Conversion runs without stalling the processor.
// - Start bit low-high-low begins conversion.
// - Busy high during conversion, then results.
// - Format bit arranges result across registers.
// - A/D clock is system clock over power-of-two.
// - Completion sets request flag, gated interrupt.
// - Rate field picks three speeds or low current; codes 0-2 time alike here, only code 3 shortens the 10-bit sample.
`timescale 1ns/1ns
`include "aic_cfg.svh"
module aic_ctrl
  import aic_pkg::*;
#(
  parameter int AW   = 8,
  parameter int N_CH = 8
) (
  // Clock and reset
  input  wire logic            aclk,
  input  wire logic            aresetn,
  // AXI4-Lite write
  input  wire logic [AW-1:0]   s_axi_awaddr,
  input  wire logic            s_axi_awvalid,
  output logic                 s_axi_awready,
  input  wire logic [31:0]     s_axi_wdata,
  input  wire logic [3:0]      s_axi_wstrb,
  input  wire logic            s_axi_wvalid,
  output logic                 s_axi_wready,
  output logic [1:0]           s_axi_bresp,
  output logic                 s_axi_bvalid,
  input  wire logic            s_axi_bready,
  // AXI4-Lite read
  input  wire logic [AW-1:0]   s_axi_araddr,
  input  wire logic            s_axi_arvalid,
  output logic                 s_axi_arready,
  output logic [31:0]          s_axi_rdata,
  output logic [1:0]           s_axi_rresp,
  output logic                 s_axi_rvalid,
  input  wire logic            s_axi_rready,
  // Analog front end
  input  wire logic            comp_i,
  output logic                 adc_power_reg,
  output logic                 adc_sample_reg,
  output logic [11:0]          sar_code_reg,
  output aic_route_s           route_reg,
  output logic                 temp_sensor_enable_reg,
  // Shared pins
  input  wire logic [N_CH-1:0] port_pullup_cfg,
  input  wire logic [N_CH-1:0] port_out_cfg,
  output logic [N_CH-1:0]      pin_pullup_en_reg,
  output logic [N_CH-1:0]      pin_out_en_reg,
  output logic [N_CH-1:0]      pin_digital_en_reg,
  // Interrupt
  output logic                 adc_irq_reg
);

  // --------------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------------
  logic            start_reg;
  logic            start_prev_reg;
  logic            fmt_reg;
  logic [3:0]      chan_reg;
  logic [2:0]      div_reg;
  logic [1:0]      ref_reg;
  logic [2:0]      ins_reg;
  logic            res_sel_reg;
  logic [1:0]      mode_reg;
  logic            gie_reg;
  logic            aie_reg;
  logic            flag_reg;
  logic [N_CH-1:0] pin_an_reg;
  aic_state_e      state_reg;
  logic [5:0]      cnt_reg;
  logic [5:0]      samp_len_reg;
  logic [3:0]      conv_len_reg;
  logic [7:0]      res_h_reg;
  logic [7:0]      res_l_reg;
  logic            busy;
  logic            start_fall;
  logic            tick;
  logic            conv_done;
  logic [3:0]      bit_idx;
  logic [11:0]     sar_final;
  logic [15:0]     res_left;
  logic [15:0]     res_right;
  logic            wr_fire;
  logic [31:0]     wr_word;
  logic [AW-1:0]   waddr;
  aic_route_s      route_next;

  // --------------------------------------------------------------------------
  // Register decode helpers
  // --------------------------------------------------------------------------
  function automatic logic [AW-1:0] align(input logic [AW-1:0] a);
    return {a[AW-1:2], 2'b00};
  endfunction

  function automatic logic mapped(input logic [AW-1:0] a);
    return align(a) <= AW'(`AIC_OFS_PIN);
  endfunction

  function automatic logic [31:0] rd_word(input logic [AW-1:0] a);
    logic [31:0] w;
    w = '0;
    case (align(a))
      AW'(`AIC_OFS_CTRL_A): w[7:0] = {chan_reg, adc_power_reg, fmt_reg, busy, start_reg};
      AW'(`AIC_OFS_CTRL_B): w[10:0] = {ins_reg, 2'b00, ref_reg, 1'b0, div_reg};
      AW'(`AIC_OFS_CTRL_C): w[3:0] = {temp_sensor_enable_reg, mode_reg, res_sel_reg};
      AW'(`AIC_OFS_RES_H):  w[7:0] = res_h_reg;
      AW'(`AIC_OFS_RES_L):  w[7:0] = res_l_reg;
      AW'(`AIC_OFS_INT):    w[2:0] = {flag_reg, aie_reg, gie_reg};
      AW'(`AIC_OFS_PIN):    w[N_CH-1:0] = pin_an_reg;
      default:              w = '0;
    endcase
    return w;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] strb);
    logic [31:0] m;
    m = old;
    for (int b = 0; b < 4; b++)
    begin
      if (strb[b])
        m[b*8 +: 8] = d[b*8 +: 8];
    end
    return m;
  endfunction

  // --------------------------------------------------------------------------
  // AXI4-Lite slave
  // --------------------------------------------------------------------------
  // Address and data are taken together in one cycle; the master offers both.
  assign wr_fire = s_axi_awready && s_axi_awvalid && s_axi_wvalid;
  assign waddr   = align(s_axi_awaddr);
  assign wr_word = merge(rd_word(s_axi_awaddr), s_axi_wdata, s_axi_wstrb);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `AIC_RESP_OKAY;
    end
    else
    begin
      s_axi_awready <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready  <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
      if (wr_fire)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= mapped(s_axi_awaddr) ? `AIC_RESP_OKAY : `AIC_RESP_SLV;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= `AIC_RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arready && s_axi_arvalid)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_word(s_axi_araddr);
        s_axi_rresp  <= mapped(s_axi_araddr) ? `AIC_RESP_OKAY : `AIC_RESP_SLV;
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // Configuration registers
  // --------------------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      start_reg              <= 1'b0;
      fmt_reg                <= 1'b0;
      adc_power_reg          <= 1'b0;
      chan_reg               <= `AIC_RST_CHAN;
      div_reg                <= `AIC_RST_DIV;
      ref_reg                <= `AIC_RST_REF;
      ins_reg                <= `AIC_RST_INS;
      res_sel_reg            <= 1'b0;
      mode_reg               <= `AIC_RST_MODE;
      temp_sensor_enable_reg <= 1'b0;
      gie_reg                <= 1'b0;
      aie_reg                <= 1'b0;
      pin_an_reg             <= '0;
    end
    else if (wr_fire)
    begin
      case (waddr)
        AW'(`AIC_OFS_CTRL_A):
        begin
          start_reg     <= wr_word[`AIC_A_START];
          fmt_reg       <= wr_word[`AIC_A_FMT];
          adc_power_reg <= wr_word[`AIC_A_PWR];
          chan_reg      <= wr_word[`AIC_A_CHAN +: 4];
        end
        AW'(`AIC_OFS_CTRL_B):
        begin
          div_reg <= wr_word[`AIC_B_DIV +: 3];
          ref_reg <= wr_word[`AIC_B_REF +: 2];
          // The forbidden internal code is dropped so the old selection stays.
          if (wr_word[`AIC_B_INS +: 3] != `AIC_INS_BAD)
            ins_reg <= wr_word[`AIC_B_INS +: 3];
        end
        AW'(`AIC_OFS_CTRL_C):
        begin
          res_sel_reg            <= wr_word[`AIC_C_RES];
          mode_reg               <= wr_word[`AIC_C_MODE +: 2];
          temp_sensor_enable_reg <= wr_word[`AIC_C_TEMP_SENSOR_ENABLE];
        end
        AW'(`AIC_OFS_INT):
        begin
          gie_reg <= wr_word[`AIC_I_GIE];
          aie_reg <= wr_word[`AIC_I_AIE];
        end
        AW'(`AIC_OFS_PIN):
          pin_an_reg <= wr_word[N_CH-1:0];
        default:
          pin_an_reg <= pin_an_reg;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Input routing and shared pins
  // --------------------------------------------------------------------------
  aic_input_mux #(
    .N_CH     (N_CH)
  ) u_mux (
    .ins_sel  (ins_reg),
    .chan_sel (chan_reg),
    .ref_sel  (ref_reg),
    .route    (route_next)
  );

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      route_reg <= '0;
    else
      route_reg <= route_next;
  end

  genvar p;
  generate
    for (p = 0; p < N_CH; p++)
    begin : g_pin
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
        begin
          pin_pullup_en_reg[p]  <= 1'b0;
          pin_out_en_reg[p]     <= 1'b0;
          pin_digital_en_reg[p] <= 1'b1;
        end
        else
        begin
          pin_pullup_en_reg[p]  <= port_pullup_cfg[p] && !pin_an_reg[p];
          pin_out_en_reg[p]     <= port_out_cfg[p] && !pin_an_reg[p];
          pin_digital_en_reg[p] <= !pin_an_reg[p];
        end
      end
    end
  endgenerate

  // --------------------------------------------------------------------------
  // Conversion sequencer
  // --------------------------------------------------------------------------
  assign busy       = (state_reg != AIC_IDLE);
  assign start_fall = start_prev_reg && !start_reg;
  assign conv_done  = adc_power_reg && (state_reg == AIC_CONV) && tick &&
                      (cnt_reg == {2'b00, conv_len_reg - 4'd1});
  assign bit_idx    = conv_len_reg - 4'd1 - cnt_reg[3:0];

  aic_clk_div #(
    .DIV_W   (3)
  ) u_div (
    .aclk    (aclk),
    .aresetn (aresetn),
    .div_sel (div_reg),
    .run     (adc_power_reg && busy),
    .tick    (tick)
  );

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      start_prev_reg <= 1'b0;
    else
      start_prev_reg <= start_reg;
  end

  // Sequencing runs in hardware only; the bus stays free meanwhile.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_reg    <= AIC_IDLE;
      cnt_reg      <= '0;
      samp_len_reg <= `AIC_SAMP_12;
      conv_len_reg <= `AIC_CONV_12;
    end
    else if (adc_power_reg)
    begin
      case (state_reg)
        AIC_IDLE:
          if (start_fall)
          begin
            state_reg    <= AIC_SAMPLE;
            cnt_reg      <= '0;
            samp_len_reg <= aic_samp_len(res_sel_reg, mode_reg, ins_reg);
            conv_len_reg <= res_sel_reg ? `AIC_CONV_10 : `AIC_CONV_12;
          end
        AIC_SAMPLE:
          if (tick)
          begin
            if (cnt_reg == samp_len_reg - 6'd1)
            begin
              state_reg <= AIC_CONV;
              cnt_reg   <= '0;
            end
            else
              cnt_reg <= cnt_reg + 6'd1;
          end
        AIC_CONV:
          if (tick)
          begin
            if (conv_done)
            begin
              state_reg <= AIC_IDLE;
              cnt_reg   <= '0;
            end
            else
              cnt_reg <= cnt_reg + 6'd1;
          end
        default:
          state_reg <= AIC_IDLE;
      endcase
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      adc_sample_reg <= 1'b0;
    else
      adc_sample_reg <= (state_reg == AIC_SAMPLE);
  end

  // One bit is decided per A/D clock, most significant first.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      sar_code_reg <= '0;
    else if (adc_power_reg && tick)
    begin
      if (state_reg == AIC_SAMPLE && cnt_reg == samp_len_reg - 6'd1)
        sar_code_reg <= 12'(12'h1 << (conv_len_reg - 4'd1));
      else if (state_reg == AIC_CONV)
      begin
        sar_code_reg[bit_idx] <= comp_i;
        if (bit_idx != 4'd0)
          sar_code_reg[bit_idx - 4'd1] <= 1'b1;
      end
    end
  end

  always_comb
  begin
    sar_final          = sar_code_reg;
    sar_final[bit_idx] = comp_i;
  end

  // --------------------------------------------------------------------------
  // Result registers and completion flag
  // --------------------------------------------------------------------------
  assign res_right = {4'h0, sar_final};
  assign res_left  = res_sel_reg ? {sar_final[9:0], 6'h00} : {sar_final, 4'h0};

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      res_h_reg <= '0;
      res_l_reg <= '0;
    end
    else if (conv_done)
    begin
      res_h_reg <= fmt_reg ? res_right[15:8] : res_left[15:8];
      res_l_reg <= fmt_reg ? res_right[7:0] : res_left[7:0];
    end
  end

  // Completion wins over a clear written in the same cycle.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      flag_reg <= 1'b0;
    else if (conv_done)
      flag_reg <= 1'b1;
    else if (wr_fire && waddr == AW'(`AIC_OFS_INT) && s_axi_wstrb[0] && s_axi_wdata[`AIC_I_FLAG])
      flag_reg <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      adc_irq_reg <= 1'b0;
    else
      adc_irq_reg <= flag_reg && gie_reg && aie_reg;
  end

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  logic [6:0] tick_total_reg;

  always_ff @(posedge aclk)
  begin
    if (!aresetn || !busy)
      tick_total_reg <= '0;
    else if (tick)
      tick_total_reg <= tick_total_reg + 7'd1;
  end

  chk_ref_route: assert property (@(posedge aclk) disable iff (!aresetn)
    (ref_reg == 2'h2) && $stable(ref_reg) |=> route_reg.ref_en == 3'b100)
    else $error("Sensor reference not routed.");

  chk_ext_route: assert property (@(posedge aclk) disable iff (!aresetn)
    (ins_reg == 3'h5) && (chan_reg == 4'h2) && $stable(chan_reg) && $stable(ins_reg)
    |=> route_reg.ext_en == 8'h04)
    else $error("External channel two not connected.");

  chk_float_chan: assert property (@(posedge aclk) disable iff (!aresetn)
    (chan_reg >= 4'(N_CH)) && $stable(chan_reg) |=> route_reg.ext_en == 8'h00)
    else $error("Absent channel drives a pin.");

  chk_int_route: assert property (@(posedge aclk) disable iff (!aresetn)
    (ins_reg == 3'h4) && $stable(ins_reg)
    |=> route_reg.gnd_en && !route_reg.tso_en && !route_reg.bandgap_en)
    else $error("Ground code routed wrongly.");

  chk_pull_off: assert property (@(posedge aclk) disable iff (!aresetn)
    pin_an_reg[0] && $stable(pin_an_reg) |=> !pin_pullup_en_reg[0] && !pin_out_en_reg[0])
    else $error("Analog pin keeps digital drive.");

  chk_conv_len: assert property (@(posedge aclk) disable iff (!aresetn)
    $fell(busy) |-> tick_total_reg == 7'(samp_len_reg) + 7'(conv_len_reg))
    else $error("Conversion length wrong.");

  chk_start_busy: assert property (@(posedge aclk) disable iff (!aresetn)
    start_fall && adc_power_reg && !busy |=> busy ##1 busy)
    else $error("Start pulse did not raise busy.");

  chk_busy_ignore: assert property (@(posedge aclk) disable iff (!aresetn)
    start_fall && busy |=> $stable(samp_len_reg) && $stable(conv_len_reg))
    else $error("Start during busy disturbed conversion.");

  chk_power_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    !adc_power_reg |=> $stable(busy) && $stable(res_h_reg) && $stable(res_l_reg))
    else $error("Powered-down converter changed state.");

  chk_irq_flag: assert property (@(posedge aclk) disable iff (!aresetn)
    $fell(busy) |-> flag_reg ##1 (adc_irq_reg == (gie_reg && aie_reg)))
    else $error("Completion did not set request.");

endmodule

// ===== testbench/aic_afe_model.sv
// Comparator model of the held analog input facing the converter.
`timescale 1ns/1ns
module aic_afe_model #(
  parameter logic [11:0] LEVEL = 12'ha5c
) (
  // Trial code in, decision out
  input  wire logic [11:0] sar_code,
  output logic             comp
);
  // The held input never moves during a conversion, so one level serves all tests.
  assign comp = (LEVEL >= sar_code);
endmodule

// ===== testbench/adc_input_ref_conversion_control_bench.sv
// Register-level bench of the A/D control block.
`timescale 1ns/1ns
module adc_input_ref_conversion_control_bench
  import aic_pkg::*;
;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00;
  logic [7:0]  s_axi_araddr = 8'h00;
  logic        s_axi_awvalid = 1'b0;
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_arvalid = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        comp_i, adc_power_reg, adc_sample_reg, temp_sensor_enable_reg, adc_irq_reg;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
  logic [31:0] s_axi_rdata, rv;
  logic [11:0] sar_code_reg;
  aic_route_s  route_reg;
  logic [7:0]  pin_pullup_en_reg, pin_out_en_reg, pin_digital_en_reg;
  int          bad_count = 0, num_checks = 0, samp_cnt = 0, cyc = 0;

  aic_ctrl i_aic_ctrl (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready(1'b1),
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready(1'b1), .comp_i, .adc_power_reg, .adc_sample_reg, .sar_code_reg, .route_reg,
    .temp_sensor_enable_reg, .port_pullup_cfg(8'hff), .port_out_cfg(8'hff), .pin_pullup_en_reg,
    .pin_out_en_reg, .pin_digital_en_reg, .adc_irq_reg);
  aic_afe_model i_aic_afe_model (.sar_code(sar_code_reg), .comp(comp_i));

  always #4 aclk = ~aclk;
  always @(posedge aclk)
  begin
    if (adc_sample_reg)
      samp_cnt <= samp_cnt + 1;
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      bad_count++;
      close_out();
    end
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Ready pulses last one cycle, so each valid is dropped at the edge that saw its own ready.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bit aw = 0, w = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(aw && w))
    begin
      @(posedge aclk);
      aw |= s_axi_awready;
      w |= s_axi_wready;
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    resp = s_axi_bresp;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    resp = s_axi_rresp;
  endtask

  // Channel is parked before the source changes, so no pin is ever shorted to an internal node.
  task automatic conv(input logic [31:0] c, input logic [31:0] b, input logic [31:0] a, input int n);
    int s0;
    wr(8'h08, c);
    wr(8'h00, a | 32'h80);
    wr(8'h04, b);
    wr(8'h00, a | 32'h1);
    s0 = samp_cnt;
    wr(8'h00, a);
    wr(8'h00, a | 32'h1);
    wr(8'h00, a);
    do rd(8'h00, rv); while (rv[1] !== 1'b0);
    chk("sample clocks", n, samp_cnt - s0);
  endtask

  initial
  begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(8'h04, rv);
    chk("ctrl_b reset", 32'h0, rv);
    rd(8'h1c, rv);
    chk("unmapped resp", 2'h2, resp);
    wr(8'h1c, 32'h1);
    chk("unmapped wresp", 2'h2, resp);
    wr(8'h18, 32'h1);
    wr(8'h14, 32'h3);
    conv(32'h0, 32'h010, 32'h008, 4);
    rd(8'h0c, rv);
    chk("res high", 32'ha5, rv);
    rd(8'h10, rv);
    chk("res low", 32'hc0, rv);
    chk("irq", 1'b1, adc_irq_reg);
    chk("ext route", 8'h01, route_reg.ext_en);
    chk("ref route", 3'h2, route_reg.ref_en);
    chk("pull-up", 8'hfe, pin_pullup_en_reg);
    chk("out enable", 8'hfe, pin_out_en_reg);
    chk("digital off", 8'hfe, pin_digital_en_reg);
    conv(32'h8, 32'h220, 32'h08c, 46);
    rd(8'h0c, rv);
    chk("res high", 32'h0a, rv);
    rd(8'h10, rv);
    chk("res low", 32'h5c, rv);
    chk("ext float", 8'h00, route_reg.ext_en);
    chk("ref route", 3'h4, route_reg.ref_en);
    chk("sensor enable", 1'b1, temp_sensor_enable_reg);
    conv(32'h7, 32'h511, 32'h028, 2 * 2);
    chk("ext route", 8'h04, route_reg.ext_en);
    rd(8'h0c, rv);
    chk("res high", 32'hff, rv);
    conv(32'h1, 32'h610, 32'h088, 3);
    wr(8'h00, 32'h089);
    wr(8'h00, 32'h088);
    wr(8'h00, 32'h080);
    chk("power off", 1'b0, adc_power_reg);
    repeat (40) @(posedge aclk);
    rd(8'h00, rv);
    chk("busy frozen", 1'b1, rv[1]);
    wr(8'h00, 32'h088);
    do rd(8'h00, rv); while (rv[1] !== 1'b0);
    for (int i = 1; i < 5; i++)
    begin
      wr(8'h04, i << 8);
      @(posedge aclk);
      chk("int route", {i == 1, i == 2, i > 2}, {route_reg.bandgap_en, route_reg.tso_en, route_reg.gnd_en});
    end
    wr(8'h04, 32'h700);
    rd(8'h04, rv);
    chk("ins kept", 3'h4, rv[10:8]);
    wr(8'h14, 32'h7);
    rd(8'h14, rv);
    chk("flag cleared", 32'h3, rv);
    close_out();
  end
endmodule
